// [inc/csw_cfg.svh]
// Chip select / wait decoder: register map, reset values, field positions
// Assumes byte addresses on a 32-bit AXI4-Lite register bus.
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH
// --------------------------------------------------
// Register byte addresses
// --------------------------------------------------
`define CSW_WIN0_ADDR 32'hFFFF_E400
`define CSW_WIN_STEP 32'h0000_0004
`define CSW_CTL01_ADDR 32'hFFFF_E480
`define CSW_CTL23_ADDR 32'hFFFF_E484
`define CSW_CTLDF_ADDR 32'hFFFF_E488
`define CSW_STAT_ADDR 32'hFFFF_E490
// --------------------------------------------------
// Reset values and writable bits
// --------------------------------------------------
`define CSW_WIN01_RST 32'h0000_00FF
`define CSW_WIN23_RST 32'h0000_01FF
`define CSW_CTL01_RST 32'h0005_0005
`define CSW_CTL23_RST 32'h0005_0805
`define CSW_CTLDF_RST 32'h0000_0005
`define CSW_CTL_WMASK 32'h08DF_08DF
`define CSW_CTLDF_WMASK 32'h0000_08DF
`define CSW_WIN_WMASK 32'hFFFF_FFFF
// --------------------------------------------------
// Fields of one 16-bit space control half
// --------------------------------------------------
`define CSW_WAVE_MSB 7
`define CSW_WAVE_LSB 6
`define CSW_WIDTH_BIT 4
`define CSW_WAIT_MSB 3
`define CSW_WAIT_LSB 0
`define CSW_EN_BIT 11
// --------------------------------------------------
// Window fields and timing codes
// --------------------------------------------------
`define CSW_MASK_LSB01 14
`define CSW_MASK_LSB23 15
`define CSW_WAVE_ROMRAM 2'h0
`define CSW_WAIT_EXT 4'hF
`define CSW_WAIT_MAXC 3'h7
`define CSW_WAIT_EXTC 3'h1
`define CSW_EXT_ADDR_W 24
`define CSW_EXCL_LO 32'hFFFF_8000
`define CSW_EXCL_HI 32'h1FFF_BFFF
`define CSW_DEFAULT_SPACE 3'h4
`define CSW_RESP_OKAY 2'h0
`define CSW_RESP_SLVERR 2'h2
`endif

// [inc/csw_pkg.sv]
// Chip select / wait decoder: shared types
// Assumes csw_cfg.svh carries all numbers.
package csw_pkg;
    // Bus-cycle controller states
    typedef enum logic [1:0] {CSW_IDLE, CSW_ACCESS, CSW_DENY} csw_state_type;
    // Space index: 0..3 windows, 4 default space
    typedef logic [2:0] csw_space_type;
    // One 16-bit space control half
    typedef logic [15:0] csw_ctl_type;
endpackage

// [verilog/csw_window_match.sv]
// One base/mask address window comparator
// Assumes window word holds base in [31:16], mask in [15:0].
`include "csw_cfg.svh"
module csw_window_match #(
    parameter int MASK_LSB = `CSW_MASK_LSB01
) (
    input wire logic [31:0] addr,
    input wire logic [31:0] window,
    input wire logic enable,
    output logic hit
);
    // --------------------------------------------------
    // Compare geometry
    // --------------------------------------------------
    localparam int CMP_W = 32 - MASK_LSB; // Compared address bits
    localparam int FIX_W = CMP_W - 16; // Always compared / below base

    // Only the two documented geometries make sense
    if (MASK_LSB < `CSW_MASK_LSB01 || MASK_LSB > `CSW_MASK_LSB23)
    begin : g_bad_lsb
        $error("csw_window_match: MASK_LSB out of range");
    end
    // Base sits on 64 KB steps; bits under A16 compare with zero
    wire logic [CMP_W-1:0] cmp_base = {window[31:16], {FIX_W{1'b0}}}; // RULE_03
    // Top bits are never maskable; mask bit 0 reaches MASK_LSB
    wire logic [CMP_W-1:0] cmp_mask = {{FIX_W{1'b0}}, window[15:0]}; // RULE_09
    // A zero mask bit includes the address bit
    wire logic [CMP_W-1:0] diff = (addr[31:MASK_LSB] ^ cmp_base) & ~cmp_mask; // RULE_16

    // Hit needs the enable and no differing compared bit
    assign hit = enable && (diff == '0); // RULE_15
endmodule // csw_window_match

// [verilog/csw_decoder.sv]
// Chip select / wait decoder: windows, AXI4-Lite registers, cycle timer
// Assumes a CPU-side request port and external ROM/RAM on cs_n.
//
// Contract
// RULE_01: Software keeps window 2/3 mask bits 9-15 zero.
// RULE_02: External address reach limited to 16 MB.
// RULE_03: Base field is start address upper 16 bits.
// RULE_04: Window 0 masks A29-A14; A31-A30 compared.
// RULE_05: Software clears window 0 mask bits 15-10.
// RULE_06: Window 2 masks A30-A15; A31 compared.
// RULE_07: Excluded address range never asserts a select.
// RULE_08: Reset: only window 2 enabled, whole space.
// RULE_09: Sizes 16K-16M for 0/1, 32K-16M 2/3.
// RULE_10: Overlap: lowest numbered space wins.
// RULE_11: Each space has its own enable.
// RULE_12: Unmatched accesses use default space settings.
// RULE_13: Waveform 00 only; width bit 0=16, 1=8.
// RULE_14: Wait code gives 0-7 or 1+N cycles.
// RULE_15: Enabled window matching compared bits drives select low.
// RULE_16: Mask zero compares bit, one excludes it.
`include "csw_cfg.svh"
module csw_decoder #(
    parameter int EXT_ADDR_W = `CSW_EXT_ADDR_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [31:0] req_addr,
    output logic rsp_valid,
    output logic rsp_err,
    input wire logic ext_wait,
    output logic [3:0] cs_n,
    output logic [EXT_ADDR_W-1:0] ext_addr,
    output logic ext_bus_8bit
);
    // --------------------------------------------------
    // Elaboration check
    // --------------------------------------------------
    // The pins stop at 16 MB; wider makes no sense here
    if (EXT_ADDR_W < 1 || EXT_ADDR_W > `CSW_EXT_ADDR_W)
    begin : g_bad_ext
        $error("csw_decoder: EXT_ADDR_W out of range");
    end

    // --------------------------------------------------
    // Register state
    // --------------------------------------------------
    logic [31:0] window_reg [4]; // Base/mask per window
    logic [31:0] ctl01_reg; // Spaces 0 and 1 control
    logic [31:0] ctl23_reg; // Spaces 2 and 3 control
    logic [31:0] ctldf_reg; // Default space control
    logic whole2_reg; // Window 2 spans all until reprogrammed
    logic aw_hold_reg; // Write address taken
    logic w_hold_reg; // Write data taken
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    // Cycle controller
    csw_pkg::csw_state_type state_reg, state_next;
    logic [2:0] cnt_reg; // Remaining wait cycles
    logic ext_mode_reg; // Wait code 1111 in use
    logic [3:0] cs_n_reg;
    logic [EXT_ADDR_W-1:0] ext_addr_reg;
    logic bus8_reg;
    logic err_reg;
    csw_pkg::csw_space_type last_space_reg; // Shown in status

    // --------------------------------------------------
    // Functions
    // --------------------------------------------------
    // First set hit, lowest index first, else default
    function automatic csw_pkg::csw_space_type first_hit(input logic [3:0] h);
        first_hit = `CSW_DEFAULT_SPACE;
        for (int i = 3; i >= 0; i--)
            if (h[i])
                first_hit = 3'(i); // RULE_10
    endfunction

    // Control half belonging to a space
    function automatic csw_pkg::csw_ctl_type space_cfg(input csw_pkg::csw_space_type s);
        case (s)
            3'h0: space_cfg = ctl01_reg[15:0];
            3'h1: space_cfg = ctl01_reg[31:16];
            3'h2: space_cfg = ctl23_reg[15:0];
            3'h3: space_cfg = ctl23_reg[31:16];
            default: space_cfg = ctldf_reg[15:0]; // RULE_12
        endcase
    endfunction

    // Byte-lane merge limited to the writable bits
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
        merge = old;
        for (int b = 0; b < 4; b++)
            if (wstrb_reg[b])
                merge[8*b +: 8] = wdata_reg[8*b +: 8];
        merge = (merge & wmask) | (old & ~wmask);
    endfunction

    // Window register address
    function automatic logic [31:0] win_addr(input int i);
        win_addr = `CSW_WIN0_ADDR + 32'(i) * `CSW_WIN_STEP;
    endfunction

    // --------------------------------------------------
    // Single clock domain for all checks
    // --------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // --------------------------------------------------
    // Window compare
    // --------------------------------------------------
    wire logic [3:0] space_en = {ctl23_reg[16+`CSW_EN_BIT], ctl23_reg[`CSW_EN_BIT],
                                 ctl01_reg[16+`CSW_EN_BIT], ctl01_reg[`CSW_EN_BIT]}; // RULE_11
    logic [3:0] raw_hit; // Comparator results
    wire logic [3:0] hits = {raw_hit[3], raw_hit[2] | (whole2_reg & space_en[2]), raw_hit[1:0]};

    // Spaces 0/1 start at A14, spaces 2/3 at A15
    for (genvar i = 0; i < 4; i++)
    begin : g_win
        csw_window_match #(
            .MASK_LSB(i < 2 ? `CSW_MASK_LSB01 : `CSW_MASK_LSB23) // RULE_04 RULE_06
        ) u_match (
            .addr(req_addr),
            .window(window_reg[i]),
            .enable(space_en[i]),
            .hit(raw_hit[i])
        );
    end

    // --------------------------------------------------
    // Space selection
    // --------------------------------------------------
    // Excluded hole; printed bounds wrap through zero
    wire logic excl_wrap = `CSW_EXCL_LO > `CSW_EXCL_HI;
    wire logic above_lo = req_addr >= `CSW_EXCL_LO;
    wire logic below_hi = req_addr <= `CSW_EXCL_HI;
    wire logic excluded = excl_wrap ? (above_lo || below_hi) : (above_lo && below_hi); // RULE_07
    wire csw_pkg::csw_space_type sel_space = first_hit(hits); // RULE_10
    wire csw_pkg::csw_ctl_type sel_cfg = space_cfg(sel_space); // RULE_12
    wire logic [1:0] sel_wave = sel_cfg[`CSW_WAVE_MSB:`CSW_WAVE_LSB];
    wire logic [3:0] sel_wait = sel_cfg[`CSW_WAIT_MSB:`CSW_WAIT_LSB];
    // Windows already carry their enable; default space needs its own
    wire logic sel_en = (sel_space == `CSW_DEFAULT_SPACE) ? sel_cfg[`CSW_EN_BIT] : 1'b1; // RULE_11
    // Only ROM/RAM waveform is served; others are refused
    wire logic sel_ok = sel_en && !excluded && (sel_wave == `CSW_WAVE_ROMRAM); // RULE_13
    // Default space has no select pin of its own
    wire logic [3:0] sel_onehot = (sel_space == `CSW_DEFAULT_SPACE || excluded)
                                  ? 4'h0 : (4'h1 << sel_space[1:0]); // RULE_15
    // Codes 1000-1110 are illegal; they fall back to the longest fixed wait
    wire logic sel_ext = sel_wait == `CSW_WAIT_EXT; // RULE_14
    wire logic [2:0] sel_load = sel_ext ? `CSW_WAIT_EXTC
                                : (sel_wait[3] ? `CSW_WAIT_MAXC : sel_wait[2:0]); // RULE_14

    // --------------------------------------------------
    // Cycle controller
    // --------------------------------------------------
    wire logic req_fire = req_valid && req_ready;
    // External wait holds the strobe only after the fixed cycle is gone
    wire logic finish = (state_reg == csw_pkg::CSW_ACCESS) && cnt_reg == 3'h0
                        && !(ext_mode_reg && ext_wait); // RULE_14
    assign req_ready = state_reg == csw_pkg::CSW_IDLE;
    assign rsp_valid = finish || state_reg == csw_pkg::CSW_DENY;
    assign rsp_err = err_reg;
    assign cs_n = cs_n_reg;
    assign ext_addr = ext_addr_reg;
    assign ext_bus_8bit = bus8_reg;

    // Next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            csw_pkg::CSW_IDLE:
                if (req_valid)
                    state_next = sel_ok ? csw_pkg::CSW_ACCESS : csw_pkg::CSW_DENY;
            csw_pkg::CSW_ACCESS:
                if (finish)
                    state_next = csw_pkg::CSW_IDLE;
            csw_pkg::CSW_DENY:
                state_next = csw_pkg::CSW_IDLE;
            default:
                state_next = csw_pkg::CSW_IDLE; // Two-bit code has a spare
        endcase
    end

    // State, strobe and latched cycle data
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= csw_pkg::CSW_IDLE;
            cnt_reg <= 3'h0;
            ext_mode_reg <= 1'b0;
            cs_n_reg <= 4'hF;
            ext_addr_reg <= '0;
            bus8_reg <= 1'b0;
            err_reg <= 1'b0;
            last_space_reg <= `CSW_DEFAULT_SPACE;
        end
        else
        begin
            state_reg <= state_next;
            if (req_fire)
            begin
                cnt_reg <= sel_load;
                ext_mode_reg <= sel_ext;
                cs_n_reg <= sel_ok ? ~sel_onehot : 4'hF; // RULE_07
                ext_addr_reg <= req_addr[EXT_ADDR_W-1:0]; // RULE_02
                bus8_reg <= sel_cfg[`CSW_WIDTH_BIT]; // RULE_13
                err_reg <= !sel_ok;
                last_space_reg <= sel_space;
            end
            else if (finish)
                cs_n_reg <= 4'hF;
            else if (state_reg == csw_pkg::CSW_ACCESS && cnt_reg != 3'h0)
                cnt_reg <= cnt_reg - 3'h1; // RULE_14
        end
    end

    // --------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------
    assign s_awready = !aw_hold_reg;
    assign s_wready = !w_hold_reg;
    assign s_bvalid = bvalid_reg;
    assign s_bresp = bresp_reg;
    // Address and data may come in either order
    wire logic wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire logic wr_ctl01 = awaddr_reg == `CSW_CTL01_ADDR;
    wire logic wr_ctl23 = awaddr_reg == `CSW_CTL23_ADDR;
    wire logic wr_ctldf = awaddr_reg == `CSW_CTLDF_ADDR;
    wire logic wr_stat = awaddr_reg == `CSW_STAT_ADDR;
    logic [3:0] wr_win; // Per-window address hit
    for (genvar i = 0; i < 4; i++)
    begin : g_wdec
        assign wr_win[i] = awaddr_reg == win_addr(i);
    end
    wire logic wr_known = (|wr_win) || wr_ctl01 || wr_ctl23 || wr_ctldf || wr_stat;

    // Handshake holding registers and response
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `CSW_RESP_OKAY;
        end
        else
        begin
            if (s_awvalid && !aw_hold_reg)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_awaddr;
            end
            if (s_wvalid && !w_hold_reg)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_wdata;
                wstrb_reg <= s_wstrb;
            end
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? `CSW_RESP_OKAY : `CSW_RESP_SLVERR;
            end
            else if (bvalid_reg && s_bready)
            begin
                bvalid_reg <= 1'b0;
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
            end
        end
    end

    // Configuration registers; status is read-only and ignores writes
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
                window_reg[i] <= (i < 2) ? `CSW_WIN01_RST : `CSW_WIN23_RST;
            ctl01_reg <= `CSW_CTL01_RST; // RULE_08
            ctl23_reg <= `CSW_CTL23_RST; // RULE_08
            ctldf_reg <= `CSW_CTLDF_RST;
            whole2_reg <= 1'b1; // RULE_08
        end
        else if (wr_fire)
        begin
            for (int i = 0; i < 4; i++)
                if (wr_win[i])
                    window_reg[i] <= merge(window_reg[i], `CSW_WIN_WMASK);
            // First window 2 write ends the catch-all reset span
            if (wr_win[2])
                whole2_reg <= 1'b0;
            if (wr_ctl01)
                ctl01_reg <= merge(ctl01_reg, `CSW_CTL_WMASK);
            if (wr_ctl23)
                ctl23_reg <= merge(ctl23_reg, `CSW_CTL_WMASK);
            if (wr_ctldf)
                ctldf_reg <= merge(ctldf_reg, `CSW_CTLDF_WMASK);
        end
    end

    // --------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------
    assign s_arready = !rvalid_reg;
    assign s_rvalid = rvalid_reg;
    assign s_rresp = rresp_reg;
    assign s_rdata = rdata_reg;
    logic [3:0] rd_win; // Per-window address hit
    for (genvar i = 0; i < 4; i++)
    begin : g_rdec
        assign rd_win[i] = s_araddr == win_addr(i);
    end
    wire logic [1:0] rd_idx = rd_win[3] ? 2'h3 : rd_win[2] ? 2'h2 : rd_win[1] ? 2'h1 : 2'h0;
    // Live status: busy, last refusal, last space
    wire logic [31:0] stat_word = {23'h0, state_reg != csw_pkg::CSW_IDLE, 3'h0, err_reg, 1'b0, last_space_reg};
    wire logic rd_known = (|rd_win) || s_araddr == `CSW_CTL01_ADDR || s_araddr == `CSW_CTL23_ADDR
                          || s_araddr == `CSW_CTLDF_ADDR || s_araddr == `CSW_STAT_ADDR;
    wire logic [31:0] rd_word = (|rd_win) ? window_reg[rd_idx]
                              : s_araddr == `CSW_CTL01_ADDR ? ctl01_reg
                              : s_araddr == `CSW_CTL23_ADDR ? ctl23_reg
                              : s_araddr == `CSW_CTLDF_ADDR ? ctldf_reg
                              : s_araddr == `CSW_STAT_ADDR ? stat_word : 32'h0000_0000;

    // One read in flight; unmapped reads answer zero with an error
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `CSW_RESP_OKAY;
            rdata_reg <= '0;
        end
        else if (s_arvalid && !rvalid_reg)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_known ? `CSW_RESP_OKAY : `CSW_RESP_SLVERR;
            rdata_reg <= rd_word;
        end
        else if (rvalid_reg && s_rready)
            rvalid_reg <= 1'b0;
    end

    // --------------------------------------------------
    // Assertions
    // --------------------------------------------------
    sequence s_take_ok;
        req_fire && sel_ok;
    endsequence
    sequence s_seven_waits;
        !rsp_valid [*7] ##1 rsp_valid;
    endsequence

    property p_reach;
        req_fire |=> ext_addr == $past(req_addr[EXT_ADDR_W-1:0]);
    endproperty
    a_reach: assert property (p_reach) else $error("external address not the low request bits"); // RULE_02

    property p_excluded;
        (req_fire && excluded) |=> cs_n == 4'hF && rsp_valid && rsp_err;
    endproperty
    a_excluded: assert property (p_excluded) else $error("select asserted in excluded range"); // RULE_07

    property p_reset_map;
        $fell(rst) |-> whole2_reg && ctl23_reg[`CSW_EN_BIT] && !ctl01_reg[`CSW_EN_BIT]
                   && !ctl01_reg[16+`CSW_EN_BIT] && !ctl23_reg[16+`CSW_EN_BIT];
    endproperty
    a_reset_map: assert property (p_reset_map) else $error("wrong space enables after reset"); // RULE_08

    property p_priority;
        (s_take_ok and (sel_space != `CSW_DEFAULT_SPACE)) |-> hits[sel_space[1:0]]
            && (hits & ((4'h1 << sel_space[1:0]) - 4'h1)) == 4'h0 ##1 !cs_n[$past(sel_space[1:0])];
    endproperty
    a_priority: assert property (p_priority) else $error("lower numbered space lost"); // RULE_10

    property p_disabled;
        (req_fire && !sel_ok) |=> rsp_valid && rsp_err ##1 req_ready;
    endproperty
    a_disabled: assert property (p_disabled) else $error("refused access not answered as error"); // RULE_11

    property p_default;
        (s_take_ok and (sel_space == `CSW_DEFAULT_SPACE)) |=> cs_n == 4'hF && !rsp_err;
    endproperty
    a_default: assert property (p_default) else $error("default space drove a select"); // RULE_12

    property p_width;
        s_take_ok |=> ext_bus_8bit == $past(sel_cfg[`CSW_WIDTH_BIT]) && !rsp_err;
    endproperty
    a_width: assert property (p_width) else $error("bus width not taken from space"); // RULE_13

    property p_wait0;
        (s_take_ok and (sel_wait == 4'h0 && !sel_space[2])) |=> rsp_valid && cs_n != 4'hF ##1 cs_n == 4'hF;
    endproperty
    a_wait0: assert property (p_wait0) else $error("zero wait cycle wrong length"); // RULE_14

    property p_wait7;
        (s_take_ok and (sel_wait == 4'h7)) |=> s_seven_waits;
    endproperty
    a_wait7: assert property (p_wait7) else $error("seven wait cycle wrong length"); // RULE_14

    property p_win0_full;
        (raw_hit[0] && window_reg[0][15:0] == 16'h0000) |-> req_addr[31:14] == {window_reg[0][31:16], 2'h0};
    endproperty
    a_win0_full: assert property (p_win0_full) else $error("window 0 hit with differing bits"); // RULE_04

    property p_win2_top;
        raw_hit[2] |-> req_addr[31] == window_reg[2][31] && space_en[2];
    endproperty
    a_win2_top: assert property (p_win2_top) else $error("window 2 hit ignored A31 or enable"); // RULE_06
endmodule // csw_decoder

// [tb/csw_mem_model.sv]
// External ROM/RAM model: stretches cycles through the wait input
// Assumes active-low select lines from the decoder.
module csw_mem_model (
    input wire logic clock,
    input wire logic [3:0] cs_n,
    input wire logic [3:0] slow_cycles,
    output logic ext_wait
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0; // Cycles selected so far
    // Restart the count whenever no select line is low
    always @(posedge clock)
        cnt <= (&cs_n) ? 0 : cnt + 1;
    // Slow device holds wait while not yet ready
    assign ext_wait = !(&cs_n) && (cnt < slow_cycles);
endmodule // csw_mem_model

// [tb/tb_chip_select_wait_decoder.sv]
// Bench: reference model of the spaces, compared at every bus cycle
// Assumes csw_cfg.svh on the include path and csw_mem_model compiled first.
`include "csw_cfg.svh"
module tb_chip_select_wait_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, rst = 1'b1, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, req_valid = 1'b0;
    logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, req_addr = '0, s_rdata, q;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, req_ready, rsp_valid, rsp_err, ext_bus_8bit, ext_wait;
    logic [1:0] s_bresp, s_rresp, rs;
    logic [3:0] cs_n, cs, slow = 4'h0;
    logic [23:0] ext_addr;
    logic [31:0] win [4]; // Model window words
    logic [15:0] ctl [6]; // Model control halves, 4 = default space
    bit w2_all = 1'b1; // Window 2 spans all until written
    int n_mismatch = 0, tests_run = 0, seed = 16, n, k;
    always #5 clock = ~clock;
    csw_decoder i_dut (.clock(clock), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .req_valid(req_valid),
        .req_ready(req_ready), .req_addr(req_addr), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .ext_wait(ext_wait),
        .cs_n(cs_n), .ext_addr(ext_addr), .ext_bus_8bit(ext_bus_8bit));
    csw_mem_model i_mem (.clock(clock), .cs_n(cs_n), .slow_cycles(slow), .ext_wait(ext_wait));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // A used-up wait bound ends the run as a mismatch
    task automatic tmo(input int i, input int lim);
        if (i == lim)
        begin
            n_mismatch++;
            complete_run();
        end
    endtask
    function automatic logic [31:0] adr(input int k);
        return k < 4 ? `CSW_WIN0_ADDR + 4 * k : `CSW_CTL01_ADDR + 4 * (k - 4);
    endfunction
    // One register access; valids released after the edge
    task automatic axi(input bit w, input logic [31:0] a, input logic [31:0] d);
        int i;
        logic aw, wd, ar, v;
        {s_awaddr, s_araddr, s_wdata} <= {a, a, d};
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= {w, w, w, !w, !w};
        for (i = 0; i < 40; i++)
        begin
            @(negedge clock);
            {aw, wd, ar, v} = {s_awready, s_wready, s_arready, w ? s_bvalid : s_rvalid};
            {q, rs} = {s_rdata, w ? s_bresp : s_rresp};
            @(posedge clock);
            if (v === 1'b1) break;
            if (aw) s_awvalid <= 1'b0;
            if (wd) s_wvalid <= 1'b0;
            if (ar) s_arvalid <= 1'b0;
        end
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= '0;
        tmo(i, 40);
        @(posedge clock);
    endtask
    // Write, update model, read back
    task automatic cfg(input int k, input logic [31:0] d);
        axi(1'b1, adr(k), d);
        chk(rs, `CSW_RESP_OKAY);
        if (k < 4) win[k] = d;
        if (k == 2) w2_all = 1'b0;
        if (k > 3) {ctl[2 * k - 7], ctl[2 * k - 8]} = d & (k == 6 ? `CSW_CTLDF_WMASK : `CSW_CTL_WMASK);
        axi(1'b0, adr(k), '0);
        chk(q, k < 4 ? win[k] : {ctl[2 * k - 7], ctl[2 * k - 8]});
    endtask
    // One bus cycle against the model: space, select, refusal, length
    task automatic run(input logic [31:0] a);
        int i, s;
        logic er, hit;
        logic [3:0] w;
        s = 4;
        for (i = 3; i >= 0; i--)
        begin
            hit = i < 2 ? ((a[31:14] ^ {win[i][31:16], 2'b00}) & ~{2'b00, win[i][15:0]}) == '0
                : ((a[31:15] ^ {win[i][31:16], 1'b0}) & ~{1'b0, win[i][15:0]}) == '0 || (i == 2 && w2_all);
            if (hit && ctl[i][11]) s = i;
        end
        er = a >= `CSW_EXCL_LO || a <= `CSW_EXCL_HI || !ctl[s][11] || ctl[s][7:6] != 2'h0;
        w = ctl[s][3:0];
        req_addr <= a;
        req_valid <= 1'b1;
        n = 0;
        cs = 4'hF;
        for (i = 0; i < 60; i++)
        begin
            @(negedge clock);
            if (n > 0) cs = cs & cs_n;
            if (n > 0 && rsp_valid === 1'b1) break;
            if (n > 0 || req_ready === 1'b1) n++;
            @(posedge clock);
            req_valid <= n == 0;
        end
        tmo(i, 60);
        chk(cs, er || s == 4 ? 4'hF : 4'(~(4'h1 << s)));
        chk(rsp_err, er);
        if (!er && w == 4'hF) chk(n, slow < 4'h2 ? 2 : slow + 1);
        else chk(n, er ? 1 : w + 1);
        if (!er) chk({ext_bus_8bit, ext_addr}, {ctl[s][4], a[23:0]});
        @(posedge clock);
    endtask
    initial
    begin
        logic [31:0] tab [7];
        logic [31:0] base [4];
        tab = '{`CSW_WIN01_RST, `CSW_WIN01_RST, `CSW_WIN23_RST, `CSW_WIN23_RST, `CSW_CTL01_RST, `CSW_CTL23_RST,
            `CSW_CTLDF_RST};
        base = '{32'hC000_0000, 32'h3FC8_0000, 32'h5000_0000, 32'h4000_0000};
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Reset values, then an unmapped read
        for (k = 0; k < 7; k++)
        begin
            axi(1'b0, adr(k), '0);
            chk(q, tab[k]);
            if (k > 3) {ctl[2 * k - 7], ctl[2 * k - 8]} = tab[k];
        end
        axi(1'b0, 32'hFFFF_E4F0, '0);
        chk({q, rs}, {32'h0000_0000, `CSW_RESP_SLVERR});
        $display("Test done: registers");
        run(32'h4000_0000);
        run(32'h0000_1000);
        run(32'hFFFF_9000);
        // Overlapping windows 0 and 1, windows 2 and 3 elsewhere
        cfg(0, 32'hC000_0000);
        cfg(1, 32'hC000_0003);
        cfg(2, 32'h3FC8_000F);
        cfg(3, 32'h5000_0000);
        cfg(4, 32'h0817_0801);
        cfg(5, 32'h0802_0813);
        for (k = 0; k < 24; k++)
            run(base[k % 4] + ($random(seed) & 32'h000F_FFFF));
        cfg(6, 32'h0000_0813);
        run(32'h4000_0000);
        $display("Test done: decode");
        // Wait codes 0-7 and 1111, then a bad waveform, then a slow device
        for (k = 0; k < 9; k++)
        begin
            cfg(4, {16'h0817, 12'h080, k == 8 ? 4'hF : 4'(k)});
            run(32'hC000_0000);
        end
        cfg(4, 32'h0817_0840);
        run(32'hC000_0000);
        cfg(4, 32'h0817_080F);
        slow <= 4'h3;
        run(32'hC000_0000);
        $display("Test done: timing");
        complete_run();
    end
endmodule // tb_chip_select_wait_decoder
